// file: design/asr_receiver.sv
// receive path with 16x sampling, error flags, sleep and wakeup, axi4-lite registers
// What this block does
// R01: receive path independent, shares one baud generator
// R02: baud generator clocked only by bus clock
// R03: full buffer on completion sets overrun, drops
// R04: data read after status read clears full
// R05: sixteen sample phases per bit time
// R06: low after three highs is falling edge
// R07: start accepted when two of 3,5,7 low
// R08: each bit decided by majority of 8,9,10
// R09: start bit zero by early majority only
// R10: any disagreeing sample sets noise on transfer; the start bit's samples 8,9,10 are taken but not checked
// R11: falling edges realign the phase counter
// R12: framing error other than break preloads three high samples, break clears them
// R13: framing error set blocks buffer transfer
// R14: sleep blocks flags except idle when enabled
// R15: idle wakeup after ten or eleven bit times
// R16: idle flag during sleep only when enabled
// R17: idle count starts after start or stop
// R18: address mark msb clears sleep
// R19: address character clears sleep, is received
// R20: completed transfer sets buffer full flag
// R21: receive events and errors on separate requests
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
module asr_receiver
    import asr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_rxd,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic o_baud_tick,
    output logic o_rx_irq,
    output logic o_err_irq
);
    // registers
    logic [7:0] ctrl_q;
    logic [15:0] div_q;
    logic [8:0] buf_q;
    logic rbf_q, idle_q, ovr_q, noise_q, frame_q, par_q;
    logic stat_seen_q;
    logic sleep_clr;
    logic addr_wake_q;

    // axi write path
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    wire wr_fire = aw_q && w_q && !bvalid_q;
    wire wr_ctrl = wr_fire && awaddr_q == ADDR_CTRL && wstrb_q[0];
    wire wr_div = wr_fire && awaddr_q == ADDR_DIV;
    wire wr_stat = wr_fire && awaddr_q == ADDR_STATUS && wstrb_q[0];
    wire wr_known = awaddr_q == ADDR_CTRL || awaddr_q == ADDR_DIV
        || awaddr_q == ADDR_STATUS || awaddr_q == ADDR_DATA;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            if (i_s_axi_awvalid && !aw_q)
            begin
                aw_q <= 1'b1;
                awaddr_q <= {i_s_axi_awaddr[7:2], 2'b00};
            end
            if (i_s_axi_wvalid && !w_q)
            begin
                w_q <= 1'b1;
                wdata_q <= i_s_axi_wdata;
                wstrb_q <= i_s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && i_s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end
    assign o_s_axi_awready = !aw_q;
    assign o_s_axi_wready = !w_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;

    // axi read path
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire rd_fire = i_s_axi_arvalid && !rvalid_q;
    wire [7:0] raddr = {i_s_axi_araddr[7:2], 2'b00};
    wire rd_data = rd_fire && raddr == ADDR_DATA;
    wire rd_stat = rd_fire && raddr == ADDR_STATUS;
    wire [7:0] status_w = {1'b0, 1'b0, par_q, frame_q, noise_q, ovr_q, idle_q, rbf_q};
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        unique case (raddr)
            ADDR_DATA: rd_mux = {23'h0, buf_q};
            ADDR_STATUS: rd_mux = {24'h0, status_w};
            ADDR_CTRL: rd_mux = {24'h0, ctrl_q};
            ADDR_DIV: rd_mux = {16'h0, div_q};
            default:
            begin
                rd_mux = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (i_s_axi_rready)
            rvalid_q <= 1'b0;
    end
    assign o_s_axi_arready = !rvalid_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rdata = rdata_q;
    assign o_s_axi_rresp = rresp_q;

    // control and divisor; hardware wakeup clears sleep and beats a same-cycle write
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            div_q <= DIV_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wdata_q[7:0];
            if (sleep_clr)
                ctrl_q[CT_SLEEP] <= 1'b0; // R15 R18
            if (wr_div)
                div_q <= (wdata_q[15:0] == 16'h0) ? 16'h1 : wdata_q[15:0];
        end
    end
    wire en = ctrl_q[CT_EN];
    wire sleep = ctrl_q[CT_SLEEP];
    wire nine = ctrl_q[CT_NINE];

    // shared baud generator on the bus clock; the transmitter would take the same tick
    logic [15:0] bcnt_q;
    logic tick_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bcnt_q <= 16'h1;
            tick_q <= 1'b0;
        end
        else if (!en || bcnt_q >= div_q)
        begin
            bcnt_q <= 16'h1; // R02
            tick_q <= en; // R01
        end
        else
        begin
            bcnt_q <= bcnt_q + 16'h1;
            tick_q <= 1'b0;
        end
    end
    assign o_baud_tick = tick_q;

    // receiver state
    asr_state_t st_q;
    logic [3:0] ph_q, bit_q;
    logic [2:0] hist_q;
    logic [2:0] smp_q;
    logic [9:0] shf_q;
    logic noisy_q;
    logic idle_run_q;
    logic [3:0] idle_bits_q;
    logic idle_done_q;

    wire rx = i_rxd;
    wire fall = tick_q && hist_q == 3'b111 && !rx; // R06
    wire [3:0] nbits = nine ? CHAR9_BITS : CHAR8_BITS;
    wire is_start_smp = ph_q == PH_START_A || ph_q == PH_START_B || ph_q == PH_START_C;
    wire is_bit_smp = ph_q == PH_BIT_A || ph_q == PH_BIT_B || ph_q == PH_BIT_C;
    wire [2:0] smp_n = {smp_q[1:0], rx};
    wire maj = (smp_n[0] & smp_n[1]) | (smp_n[0] & smp_n[2]) | (smp_n[1] & smp_n[2]); // R08
    wire start_ok = !maj; // R07
    wire disagree = smp_n != {3{maj}};
    wire bit_end = tick_q && ph_q == PH_LAST;
    wire last_bit = bit_q == nbits - 4'h1;
    wire stop_lvl = smp_q[0] & smp_q[1] | smp_q[0] & smp_q[2] | smp_q[1] & smp_q[2];
    wire frame_done = st_q == ASR_DATA && bit_end && last_bit;
    // stop bit sits in bit 9; the start bit is already shifted out in nine-bit mode
    wire [8:0] data_w = nine ? shf_q[8:0] : {1'b0, shf_q[8:1]};
    wire brk = frame_done && !stop_lvl && data_w == 9'h0;
    wire ferr = frame_done && !stop_lvl;
    wire xfer_ok = frame_done && stop_lvl && !frame_q; // R13
    wire flags_ok = !sleep; // R14
    wire msb_now = st_q == ASR_DATA && bit_end && bit_q == nbits - 4'h2 && stop_lvl;
    wire addr_wake = ctrl_q[CT_WAKE] && sleep && msb_now; // R19
    wire idle_hit = idle_run_q && tick_q && ph_q == PH_LAST && idle_bits_q == nbits - 4'h1;
    wire idle_wake = !ctrl_q[CT_WAKE] && sleep && idle_hit && !idle_done_q;
    assign sleep_clr = addr_wake || idle_wake; // R15 R18

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= ASR_HUNT;
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            hist_q <= 3'b000;
            smp_q <= 3'b000;
            shf_q <= 10'h0;
            noisy_q <= 1'b0;
        end
        else if (!en)
        begin
            st_q <= ASR_HUNT;
            hist_q <= 3'b000;
        end
        else if (tick_q)
        begin
            hist_q <= {hist_q[1:0], rx};
            ph_q <= ph_q + 4'h1; // R05
            if (is_start_smp || is_bit_smp)
                smp_q <= smp_n;
            // the edge sample itself was the first phase
            if (fall)
                ph_q <= 4'h1; // R11
            unique case (st_q)
                ASR_HUNT:
                    if (fall)
                    begin
                        st_q <= ASR_START;
                        noisy_q <= 1'b0;
                        bit_q <= 4'h0;
                    end
                ASR_START:
                    if (ph_q == PH_START_C)
                    begin
                        if (start_ok)
                            st_q <= ASR_DATA; // R09
                        else
                            st_q <= ASR_HUNT;
                        noisy_q <= disagree;
                    end
                ASR_DATA:
                begin
                    if (ph_q == PH_BIT_C)
                    begin
                        if (bit_q != 4'h0)
                            noisy_q <= noisy_q | disagree; // R10
                        shf_q <= {maj, shf_q[9:1]};
                    end
                    if (ph_q == PH_LAST)
                    begin
                        bit_q <= bit_q + 4'h1;
                        if (last_bit)
                        begin
                            st_q <= ASR_HUNT;
                            // a clean stop keeps its high history so a back-to-back start is seen
                            if (ferr && !brk)
                                hist_q <= 3'b111; // R12
                            else if (brk)
                                hist_q <= 3'b000;
                        end
                    end
                end
                default: st_q <= ASR_HUNT;
            endcase
        end
    end

    // idle counter: whole bit times of high line
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idle_run_q <= 1'b0;
            idle_bits_q <= 4'h0;
            idle_done_q <= 1'b1;
        end
        else if (st_q == ASR_START && tick_q && ph_q == PH_START_C && start_ok)
        begin
            idle_run_q <= !ctrl_q[CT_ILT]; // R17
            idle_bits_q <= 4'h0;
            idle_done_q <= 1'b0;
        end
        else if (frame_done && ctrl_q[CT_ILT])
        begin
            idle_run_q <= 1'b1; // R17
            idle_bits_q <= 4'h0;
        end
        // one below zero: the low bit's own end brings the count back to zero
        else if (idle_run_q && tick_q && ph_q == PH_BIT_B && !rx)
            idle_bits_q <= 4'hf;
        else if (idle_run_q && tick_q && ph_q == PH_LAST)
        begin
            if (idle_hit)
            begin
                idle_run_q <= 1'b0;
                idle_done_q <= 1'b1;
            end
            else
                idle_bits_q <= idle_bits_q + 4'h1;
        end
    end
    wire idle_set = idle_hit && !idle_done_q
        && (flags_ok && !idle_wake || ctrl_q[CT_SLEEPID]); // R16

    // status flags: set wins over clear
    wire clr_rbf = rd_data && stat_seen_q && rbf_q; // R04
    wire w1c = wr_stat;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rbf_q <= 1'b0;
            idle_q <= 1'b0;
            ovr_q <= 1'b0;
            noise_q <= 1'b0;
            frame_q <= 1'b0;
            par_q <= 1'b0;
            buf_q <= 9'h0;
            stat_seen_q <= 1'b0;
        end
        else
        begin
            if (rd_stat)
                stat_seen_q <= 1'b1;
            else if (rd_data)
                stat_seen_q <= 1'b0;
            if (clr_rbf)
                rbf_q <= 1'b0;
            if (w1c && wdata_q[ST_IDLE])
                idle_q <= 1'b0;
            if (w1c && wdata_q[ST_OVR])
                ovr_q <= 1'b0;
            if (w1c && wdata_q[ST_NOISE])
                noise_q <= 1'b0;
            if (w1c && wdata_q[ST_FRAME])
                frame_q <= 1'b0;
            if (w1c && wdata_q[ST_PAR])
                par_q <= 1'b0;
            if (idle_set)
                idle_q <= 1'b1; // R16
            if (ferr && flags_ok)
                frame_q <= 1'b1;
            if (xfer_ok && (flags_ok || addr_wake_q))
            begin
                if (rbf_q && !clr_rbf)
                    ovr_q <= 1'b1; // R03
                else
                begin
                    buf_q <= data_w;
                    rbf_q <= 1'b1; // R20
                    if (noisy_q)
                        noise_q <= 1'b1; // R10
                end
            end
        end
    end

    // remember an address wakeup until the stop bit lands
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            addr_wake_q <= 1'b0;
        else if (addr_wake)
            addr_wake_q <= 1'b1; // R19
        else if (frame_done)
            addr_wake_q <= 1'b0;
    end

    // interrupt requests, one per group
    logic rx_irq_q, err_irq_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_irq_q <= 1'b0;
            err_irq_q <= 1'b0;
        end
        else
        begin
            rx_irq_q <= ctrl_q[CT_RIE] && (rbf_q || idle_q); // R21
            err_irq_q <= ctrl_q[CT_EIE] && (ovr_q || noise_q || frame_q || par_q); // R21
        end
    end
    assign o_rx_irq = rx_irq_q;
    assign o_err_irq = err_irq_q;

    // checks
    a_overrun_keeps_buf: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        xfer_ok && flags_ok && rbf_q && !clr_rbf |=> ovr_q && $stable(buf_q)) // R03
        else $error("overrun changed the buffer");
    a_full_clear_seq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_data && stat_seen_q && rbf_q && !xfer_ok |=> !rbf_q) // R04
        else $error("full flag not cleared by data read");
    a_frame_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        frame_q && frame_done |=> $stable(buf_q)) // R13
        else $error("transfer while framing error set");
    a_sleep_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sleep && !addr_wake_q && !addr_wake && !noise_q |=> !$rose(noise_q)) // R14
        else $error("flag set during sleep");
    a_edge_resync: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        en && fall |=> ph_q == 4'h1) // R11
        else $error("phase not realigned on edge");
    a_wake_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sleep_clr && !wr_ctrl |=> !ctrl_q[CT_SLEEP]) // R15
        else $error("sleep not cleared on wakeup");
    a_start_reject: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        en && tick_q && st_q == ASR_START && ph_q == PH_START_C && maj |=> st_q == ASR_HUNT) // R07
        else $error("noise accepted as start bit");
    a_preload_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        en && tick_q && ferr && !brk |=> hist_q == 3'b111) // R12
        else $error("edge history not preloaded");
    c_frame_rx: cover property (@(posedge i_clk) disable iff (!i_rst_n) xfer_ok && !rbf_q);
    c_overrun: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(ovr_q));
    c_idle_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n) idle_wake);
    c_addr_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n) addr_wake);
endmodule // asr_receiver

// file: dv/asr_line_model.sv
// remote serial transmitter model driving the receive line
module asr_line_model #(
    parameter int BIT_CYC = 32
) (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [8:0] i_data,
    input wire logic i_nine,
    input wire logic i_bad_stop,
    input wire logic i_noisy,
    output logic o_txd,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] frame;
    logic flip;
    int nbits;
    initial
    begin
        o_txd = 1'b1;
        o_busy = 1'b0;
    end
    // lsb first; a low stop bit on request forces a framing error
    always @(posedge i_clk)
    begin
        if (i_go && !o_busy)
        begin
            nbits = i_nine ? 11 : 10;
            frame = i_nine ? {~i_bad_stop, i_data, 1'b0} : {1'b0, ~i_bad_stop, i_data[7:0], 1'b0};
            o_busy <= 1'b1;
            for (int k = 0; k < nbits; k++)
            begin
                for (int c = 0; c < BIT_CYC; c++)
                begin
                    // two-cycle flip near mid-bit: one bad sample, not a level change
                    flip = i_noisy && k == 1 && c >= BIT_CYC / 2 && c < BIT_CYC / 2 + 2;
                    o_txd <= frame[k] ^ flip;
                    @(posedge i_clk);
                end
            end
            o_txd <= 1'b1;
            o_busy <= 1'b0;
        end
    end
endmodule // asr_line_model

// file: dv/async_serial_receiver_wakeup_bench.sv
// self-checking bench for the serial receiver with wakeup
module async_serial_receiver_wakeup_bench import asr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // divisor 2 gives 16 ticks of 2 cycles per bit
    localparam int BIT_CYC = 32;
    logic i_clk, i_rst_n, rxd, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, go, nine, bad, noisy, busy, rx_irq, err_irq, tick;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [1:0] bresp, rresp, rr, wresp;
    logic [8:0] sdata;
    int miscompares = 0;
    int comparisons = 0;
    int nticks = 0;
    int cycles = 0;

    always #10 i_clk = ~i_clk;

    asr_receiver u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rxd(rxd),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_baud_tick(tick),
        .o_rx_irq(rx_irq), .o_err_irq(err_irq)
    );

    asr_line_model #(.BIT_CYC(BIT_CYC)) u_line (
        .i_clk(i_clk), .i_go(go), .i_data(sdata), .i_nine(nine),
        .i_bad_stop(bad), .i_noisy(noisy), .o_txd(rxd), .o_busy(busy)
    );

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // handshakes are judged at the falling edge, acted on after the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb)
        begin
            @(negedge i_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            wresp = bresp;
            @(posedge i_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr)
        begin
            @(negedge i_clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge i_clk);
            if (ta)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d & m);
    endtask

    task automatic sd(input logic [8:0] d, input logic n, input logic b, input logic z);
        @(posedge i_clk);
        sdata <= d;
        nine <= n;
        bad <= b;
        noisy <= z;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        while (busy)
            @(posedge i_clk);
        repeat (4) @(posedge i_clk);
    endtask

    initial
    begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, go, nine, bad, noisy} = 9'h000;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        sdata = 9'h000;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rc(ADDR_DIV, 32'hffff, 32'(DIV_RESET), "div reset");
        rc(ADDR_CTRL, 32'hff, 32'(CTRL_RESET), "ctrl reset");
        rc(ADDR_STATUS, 32'h7f, 32'h0, "status reset");
        rd(8'h10, st, rr);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(rr));
        chk("unmapped data", 32'h0, st);
        wr(8'h10, 32'h0);
        chk("unmapped wresp", 32'(RESP_SLVERR), 32'(wresp));
        wr(ADDR_DIV, 32'h2);
        chk("div wresp", 32'(RESP_OKAY), 32'(wresp));
        wr(ADDR_CTRL, 32'hc1);
        repeat (20)
        begin
            @(posedge i_clk);
            if (tick === 1'b1)
                nticks++;
        end
        chk("tick count", 32'd10, 32'(nticks));
        sd(9'h05a, 1'b0, 1'b0, 1'b0);
        chk("rx irq", 32'h1, 32'(rx_irq));
        rc(ADDR_STATUS, 32'h1d, 32'h01, "full set");
        rc(ADDR_DATA, 32'h1ff, 32'h05a, "data");
        rc(ADDR_STATUS, 32'h1d, 32'h00, "full cleared");
        sd(9'h011, 1'b0, 1'b0, 1'b0);
        sd(9'h022, 1'b0, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h1d, 32'h05, "overrun");
        rc(ADDR_DATA, 32'h1ff, 32'h011, "kept data");
        wr(ADDR_STATUS, 32'h3e);
        sd(9'h05a, 1'b0, 1'b0, 1'b1);
        chk("err irq", 32'h1, 32'(err_irq));
        rc(ADDR_STATUS, 32'h1d, 32'h09, "noise");
        rc(ADDR_DATA, 32'h1ff, 32'h05a, "noisy data");
        wr(ADDR_STATUS, 32'h3e);
        sd(9'h033, 1'b0, 1'b1, 1'b0);
        rc(ADDR_STATUS, 32'h1d, 32'h10, "framing");
        sd(9'h044, 1'b0, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h1d, 32'h10, "blocked");
        wr(ADDR_STATUS, 32'h3e);
        sd(9'h055, 1'b0, 1'b0, 1'b0);
        rc(ADDR_STATUS, 32'h1d, 32'h01, "after clear");
        rc(ADDR_DATA, 32'h1ff, 32'h055, "after data");
        repeat (400) @(posedge i_clk);
        rc(ADDR_STATUS, 32'h02, 32'h02, "idle");
        wr(ADDR_STATUS, 32'h3e);
        sd(9'h0ff, 1'b0, 1'b0, 1'b0);
        repeat (100) @(posedge i_clk);
        rc(ADDR_STATUS, 32'h02, 32'h02, "idle early");
        wr(ADDR_STATUS, 32'h3e);
        wr(ADDR_CTRL, 32'hd1);
        sd(9'h0ff, 1'b0, 1'b0, 1'b0);
        repeat (100) @(posedge i_clk);
        rc(ADDR_STATUS, 32'h02, 32'h00, "idle late");
        repeat (300) @(posedge i_clk);
        rc(ADDR_STATUS, 32'h02, 32'h02, "idle after stop");
        rc(ADDR_DATA, 32'h1ff, 32'h0ff, "idle data");
        wr(ADDR_STATUS, 32'h3e);
        wr(ADDR_CTRL, 32'h03);
        sd(9'h066, 1'b0, 1'b0, 1'b0);
        rc(ADDR_CTRL, 32'h02, 32'h02, "still asleep");
        repeat (400) @(posedge i_clk);
        rc(ADDR_CTRL, 32'h02, 32'h00, "idle wake");
        rc(ADDR_STATUS, 32'h1f, 32'h00, "sleep flags");
        wr(ADDR_CTRL, 32'h23);
        sd(9'h066, 1'b0, 1'b0, 1'b0);
        repeat (400) @(posedge i_clk);
        rc(ADDR_STATUS, 32'h03, 32'h02, "idle in sleep");
        wr(ADDR_STATUS, 32'h3e);
        wr(ADDR_CTRL, 32'h07);
        sd(9'h005, 1'b0, 1'b0, 1'b0);
        rc(ADDR_CTRL, 32'h02, 32'h02, "addr asleep");
        rc(ADDR_STATUS, 32'h1d, 32'h00, "addr blocked");
        sd(9'h085, 1'b0, 1'b0, 1'b0);
        rc(ADDR_CTRL, 32'h02, 32'h00, "addr woke");
        rc(ADDR_STATUS, 32'h1d, 32'h01, "addr full");
        rc(ADDR_DATA, 32'h1ff, 32'h085, "addr data");
        wr(ADDR_CTRL, 32'h0f);
        sd(9'h0a5, 1'b1, 1'b0, 1'b0);
        rc(ADDR_CTRL, 32'h02, 32'h02, "nine asleep");
        sd(9'h1a5, 1'b1, 1'b0, 1'b0);
        rc(ADDR_CTRL, 32'h02, 32'h00, "nine woke");
        rc(ADDR_STATUS, 32'h1d, 32'h01, "nine full");
        rc(ADDR_DATA, 32'h1ff, 32'h1a5, "nine data");
        end_sim();
    end
endmodule // async_serial_receiver_wakeup_bench

// file: pkg/asr_pkg.sv
// package for the asynchronous serial receiver with wakeup
package asr_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BAUD_HZ = 9600;
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [15:0] DIV_RESET = 16'((CLK_HZ + (BAUD_HZ * OVERSAMPLE) / 2) / (BAUD_HZ * OVERSAMPLE));
    // register byte addresses
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DIV = 8'h0c;
    // status bit positions
    localparam int unsigned ST_RBF = 0;
    localparam int unsigned ST_IDLE = 1;
    localparam int unsigned ST_OVR = 2;
    localparam int unsigned ST_NOISE = 3;
    localparam int unsigned ST_FRAME = 4;
    localparam int unsigned ST_PAR = 5;
    localparam int unsigned ST_ACTIVE = 6;
    // control bit positions
    localparam int unsigned CT_EN = 0;
    localparam int unsigned CT_SLEEP = 1;
    localparam int unsigned CT_WAKE = 2;
    localparam int unsigned CT_NINE = 3;
    localparam int unsigned CT_ILT = 4;
    localparam int unsigned CT_SLEEPID = 5;
    localparam int unsigned CT_RIE = 6;
    localparam int unsigned CT_EIE = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // sample phases, numbered 1..16 held as 0..15
    localparam logic [3:0] PH_START_A = 4'h2;
    localparam logic [3:0] PH_START_B = 4'h4;
    localparam logic [3:0] PH_START_C = 4'h6;
    localparam logic [3:0] PH_BIT_A = 4'h7;
    localparam logic [3:0] PH_BIT_B = 4'h8;
    localparam logic [3:0] PH_BIT_C = 4'h9;
    localparam logic [3:0] PH_LAST = 4'hf;
    localparam logic [3:0] CHAR8_BITS = 4'ha;
    localparam logic [3:0] CHAR9_BITS = 4'hb;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ASR_HUNT = 2'b00,
        ASR_START = 2'b01,
        ASR_DATA = 2'b10
    } asr_state_t;
endpackage
